// ### core/esb_pkg.sv
package esb_pkg;

   // status word field positions
   localparam int ESB_CB_HI_MSB    = 26;
   localparam int ESB_CB_HI_LSB    = 25;
   localparam int ESB_ISTATE_POS   = 24;
   localparam int ESB_RSV_HI_MSB   = 23;
   localparam int ESB_RSV_HI_LSB   = 16;
   localparam int ESB_CB_LO_MSB    = 15;
   localparam int ESB_CB_LO_LSB    = 10;
   localparam int ESB_RSV_LO_MSB   = 9;
   localparam int ESB_RSV_LO_LSB   = 6;
   localparam int ESB_BLOCK_MAX    = 4;

   // reset values
   localparam logic [7:0] ESB_CB_RESET     = 8'h00;
   localparam logic       ESB_ISTATE_RESET = 1'b1;
   localparam logic [3:0] ESB_REG_RESET    = 4'h0;

   // status word view selectors
   typedef enum logic [1:0] {
      ESB_VIEW_FULL  = 2'b00,
      ESB_VIEW_EXEC  = 2'b01,
      ESB_VIEW_OTHER = 2'b10
   } esb_view_t;

   // source of an instruction-set state update
   typedef enum logic [1:0] {
      ESB_ISRC_NONE   = 2'b00,
      ESB_ISRC_BRANCH = 2'b01,
      ESB_ISRC_RETURN = 2'b10,
      ESB_ISRC_VECTOR = 2'b11
   } esb_isrc_t;

   // state of the split field
   typedef enum logic [1:0] {
      ESB_MODE_IDLE  = 2'b00,
      ESB_MODE_BLOCK = 2'b01,
      ESB_MODE_MULTI = 2'b10
   } esb_mode_t;

   // pipeline events that steer the execution state
   typedef struct packed {
      logic       block_start;   // conditional-block prefix retired
      logic [7:0] block_state;   // condition and mask from the prefix
      logic       block_step;    // one instruction of the block retired
      logic       multi_suspend; // interrupt taken inside a multiple transfer
      logic [3:0] multi_next;    // next register operand of that transfer
      logic       multi_resume;  // transfer resumed after the handler
      logic       multi_done;    // resumed transfer finished
   } esb_event_t;

   // software access to the status word
   typedef struct packed {
      logic        rd;
      logic        wr;
      esb_view_t   view;
      logic        privileged;
      logic [31:0] wdata;
   } esb_sw_t;

endpackage : esb_pkg

// ### core/esb_block_stepper.sv
`timescale 1ns/100ps
// advances the conditional-block state by one instruction
module esb_block_stepper
   import esb_pkg::*;
(
   // current state
   input  wire logic [7:0] cur_state,
   // advanced state and the condition of the next instruction
   output logic      [7:0] nxt_state,
   output logic      [3:0] cond
);

   // shift the mask, keep the base condition; zero once the mask runs out
   always_comb begin
      cond = cur_state[7:4];
      if (cur_state[2:0] == 3'h0) begin
         nxt_state = 8'h00;
      end else begin
         nxt_state = {cur_state[7:5], cur_state[4:0] << 1};
      end
   end

endmodule : esb_block_stepper

// ### core/esb_exec_state.sv
`timescale 1ns/100ps
// What this block does
// - the continuation/conditional-block state is split over read-only bits 26:25 and 15:10.
// - while the split field holds multiple-transfer state, bits 26:25 and 11:10 read zero.
// - the conditional-block state covers at most four instructions after the prefix.
// - bit 24 is a read-only instruction-set state bit that resets to one.
// - bit 24 changes only on register branch or pop to pc, exception return, or vector load.
// - executing with bit 24 clear raises a fault instead of running the instruction.
// - an interrupt inside a multiple transfer records the next register number in bits 15:12.
// - after the handler the transfer resumes at the recorded register, not the first.
// - reserved bits 23:16 and 9:6 read zero and ignore writes.
// - both parts of the split field are read-only to software and reset to zero.
// - execution-state bits show only in privileged reads of the full view and the execution-state view.
// - unprivileged reads of the execution-state view give zero and its writes are ignored.
module esb_exec_state
   import esb_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // pipeline events
   input  esb_event_t       evt,
   input  wire logic        exec_attempt,
   // instruction-set state update
   input  esb_isrc_t        isrc,
   input  wire logic        isrc_bit,
   // restore of the stacked status word on exception return
   input  wire logic [31:0] stacked_word,
   // software access
   input  esb_sw_t          sw,
   // read data and state
   output logic      [31:0] rd_data,
   output logic             rd_valid,
   output logic      [3:0]  resume_reg,
   output logic             resume_valid,
   output logic      [3:0]  block_cond,
   output logic             block_active,
   output logic             exec_fault
);

   ////////////////////////////////////////////////////////////////////////
   // state registers
   esb_mode_t   mode;
   esb_mode_t   next_mode;
   logic [7:0]  split;
   logic [7:0]  next_split;
   logic        istate;
   logic        next_istate;
   logic [7:0]  step_state;
   logic [31:0] next_rd_data;
   logic        next_rd_valid;
   logic [3:0]  next_resume_reg;
   logic        next_resume_valid;
   logic        next_exec_fault;
   logic [31:0] word;

   esb_block_stepper u_stepper (
      .cur_state (split),
      .nxt_state (step_state),
      .cond      ()
   );

   ////////////////////////////////////////////////////////////////////////
   // split field and instruction-set state
   always_comb begin
      next_mode   = mode;
      next_split  = split;
      next_istate = istate;
      // software writes never reach the split field or bit 24
      if (evt.multi_suspend) begin
         next_mode  = ESB_MODE_MULTI;
         next_split = {2'b00, evt.multi_next, 2'b00};
      end else if (mode == ESB_MODE_MULTI && evt.multi_done) begin
         next_mode  = ESB_MODE_IDLE;
         next_split = ESB_CB_RESET;
      end else if (evt.block_start) begin
         next_mode  = ESB_MODE_BLOCK;
         next_split = evt.block_state;
      end else if (mode == ESB_MODE_BLOCK && evt.block_step) begin
         next_split = step_state;
         if (step_state[3:0] == 4'h0) begin
            next_mode = ESB_MODE_IDLE;
         end
      end
      // only three sources may update bit 24
      case (isrc)
         ESB_ISRC_BRANCH: next_istate = isrc_bit;
         ESB_ISRC_RETURN: next_istate = stacked_word[ESB_ISTATE_POS];
         ESB_ISRC_VECTOR: next_istate = isrc_bit;
         default:         next_istate = istate;
      endcase
      if (isrc == ESB_ISRC_RETURN) begin
         next_split = {stacked_word[ESB_CB_HI_MSB:ESB_CB_HI_LSB],
                       stacked_word[ESB_CB_LO_MSB:ESB_CB_LO_LSB]};
         if (next_split == ESB_CB_RESET) begin
            next_mode = ESB_MODE_IDLE;
         end else if (next_split[7:6] == 2'b00 && next_split[1:0] == 2'b00) begin
            next_mode = ESB_MODE_MULTI;
         end else begin
            next_mode = ESB_MODE_BLOCK;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mode   <= ESB_MODE_IDLE;
         split  <= ESB_CB_RESET;
         istate <= ESB_ISTATE_RESET;
      end else begin
         mode   <= next_mode;
         split  <= next_split;
         istate <= next_istate;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status word assembly and outputs
   always_comb begin
      word = 32'h0000_0000;
      word[ESB_CB_HI_MSB:ESB_CB_HI_LSB] = split[7:6];
      word[ESB_ISTATE_POS]              = istate;
      word[ESB_CB_LO_MSB:ESB_CB_LO_LSB] = split[5:0];
      if (mode == ESB_MODE_MULTI) begin
         word[ESB_CB_HI_MSB:ESB_CB_HI_LSB] = 2'b00;
         word[11:10]                       = 2'b00;
      end
      next_rd_data  = 32'h0000_0000;
      next_rd_valid = sw.rd;
      if (sw.rd) begin
         case (sw.view)
            ESB_VIEW_FULL:  next_rd_data = sw.privileged ? word : 32'h0000_0000;
            ESB_VIEW_EXEC:  next_rd_data = sw.privileged ? word : 32'h0000_0000;
            default:        next_rd_data = 32'h0000_0000;
         endcase
      end
      // recorded register shows in the same cycle as the suspend lands in the split field
      next_resume_reg   = (next_mode == ESB_MODE_MULTI) ? next_split[5:2] : ESB_REG_RESET;
      next_resume_valid = (mode == ESB_MODE_MULTI) && evt.multi_resume;
      next_exec_fault   = exec_attempt && !istate;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rd_data      <= 32'h0000_0000;
         rd_valid     <= 1'b0;
         resume_reg   <= ESB_REG_RESET;
         resume_valid <= 1'b0;
         block_cond   <= 4'h0;
         block_active <= 1'b0;
         exec_fault   <= 1'b0;
      end else begin
         rd_data      <= next_rd_data;
         rd_valid     <= next_rd_valid;
         resume_reg   <= next_resume_reg;
         resume_valid <= next_resume_valid;
         block_cond   <= next_split[7:4];
         block_active <= (next_mode == ESB_MODE_BLOCK);
         exec_fault   <= next_exec_fault;
      end
   end

endmodule : esb_exec_state

// ### dv/esb_exec_state_properties.sv
`timescale 1ns/100ps
// watches the execution-state block from its ports
module esb_exec_state_properties
   import esb_pkg::*;
(
   // clock and inputs
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input esb_event_t       evt,
   input wire logic        exec_attempt,
   input esb_isrc_t        isrc,
   input wire logic        isrc_bit,
   input wire logic [31:0] stacked_word,
   input esb_sw_t          sw,
   // outputs
   input wire logic [31:0] rd_data,
   input wire logic        rd_valid,
   input wire logic [3:0]  resume_reg,
   input wire logic        resume_valid,
   input wire logic [3:0]  block_cond,
   input wire logic        block_active,
   input wire logic        exec_fault
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic [2:0] steps;
   logic [2:0] next_steps;
   ////////////////////////////////////////
   // counts block instructions retired since the prefix
   always_comb begin
      next_steps = (evt.block_step && block_active) ? steps + 3'h1 : steps;
      if (evt.block_start) next_steps = 3'h0;
   end
   always_ff @(posedge sys_clk) begin
      steps <= rst_n ? next_steps : 3'h0;
   end
   read_answer_a: assert property (sw.rd |=> rd_valid) else $error("read not answered");
   rsv_zero_a: assert property (rd_valid |-> rd_data[23:16] == 8'h00 && rd_data[9:6] == 4'h0)
      else $error("reserved bits set");
   unpriv_read_a: assert property (sw.rd && !sw.privileged |=> rd_data == 32'h0)
      else $error("unprivileged read not zero");
   other_view_a: assert property (sw.rd && sw.view == ESB_VIEW_OTHER |=> rd_data[26:24] == 3'h0 &&
      rd_data[15:10] == 6'h00) else $error("state visible in other view");
   multi_record_a: assert property (evt.multi_suspend |=> resume_reg == $past(evt.multi_next))
      else $error("next register not recorded");
   multi_hide_a: assert property (evt.multi_suspend ##1 (sw.rd && sw.privileged) |=>
      rd_data[26:25] == 2'h0 && rd_data[11:10] == 2'h0) else $error("multi state bits not zero");
   resume_pulse_a: assert property (resume_valid |-> $past(evt.multi_resume)) else $error("stray resume");
   fault_cause_a: assert property (exec_fault |-> $past(exec_attempt)) else $error("stray fault");
   block_len_a: assert property (block_active |-> steps < 3'h4) else $error("block too long");
endmodule : esb_exec_state_properties
bind esb_exec_state esb_exec_state_properties chk_u (.sys_clk, .rst_n, .evt, .exec_attempt, .isrc, .isrc_bit,
   .stacked_word, .sw, .rd_data, .rd_valid, .resume_reg, .resume_valid, .block_cond, .block_active, .exec_fault);

// ### dv/execution_state_bits_test.sv
`timescale 1ns/100ps
// drives the execution-state block and checks its answers
module execution_state_bits_test
   import esb_pkg::*;
();
   logic        sys_clk, rst_n, exec_attempt, isrc_bit, rd_valid, resume_valid, block_active, exec_fault;
   esb_event_t  evt;
   esb_event_t  e;
   esb_isrc_t   isrc;
   esb_sw_t     sw;
   logic [31:0] stacked_word, rd_data;
   logic [3:0]  resume_reg, block_cond;
   int          fail_count = 0;
   int          n_compared = 0;
   ////////////////////////////////////////
   always #5 sys_clk = ~sys_clk;
   esb_exec_state dut_u (.sys_clk, .rst_n, .evt, .exec_attempt, .isrc, .isrc_bit, .stacked_word, .sw,
      .rd_data, .rd_valid, .resume_reg, .resume_valid, .block_cond, .block_active, .exec_fault);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input esb_view_t v, input logic p, input logic [31:0] x);
      @(posedge sys_clk) begin
         sw.rd <= 1'b1;
         sw.view <= v;
         sw.privileged <= p;
      end
      @(posedge sys_clk) sw.rd <= 1'b0;
      #1 chk({rd_valid, rd_data}, {1'b1, x});
   endtask : rd
   // one-cycle event, returns just after the answer lands
   task automatic ev;
      @(posedge sys_clk) evt <= e;
      @(posedge sys_clk) evt <= '0;
      #1;
   endtask : ev
   task automatic upd(input esb_isrc_t s, input logic b, input logic [31:0] w);
      @(posedge sys_clk) begin
         isrc <= s;
         isrc_bit <= b;
         stacked_word <= w;
      end
      @(posedge sys_clk) isrc <= ESB_ISRC_NONE;
   endtask : upd
   task automatic ex(input logic f);
      @(posedge sys_clk) exec_attempt <= 1'b1;
      @(posedge sys_clk) exec_attempt <= 1'b0;
      #1 chk({31'h0, exec_fault}, {31'h0, f});
   endtask : ex
   task automatic t_reset;
      rd(ESB_VIEW_FULL, 1'b1, 32'h01000000);
      rd(ESB_VIEW_EXEC, 1'b0, 32'h00000000);
      @(posedge sys_clk) sw <= '{1'b0, 1'b1, ESB_VIEW_EXEC, 1'b1, 32'hFFFFFFFF};
      @(posedge sys_clk) sw.wr <= 1'b0;
      rd(ESB_VIEW_EXEC, 1'b1, 32'h01000000);
   endtask : t_reset
   task automatic t_multi;
      e = '0; e.multi_suspend = 1'b1; e.multi_next = 4'h5; ev;
      rd(ESB_VIEW_FULL, 1'b1, 32'h01005000);
      e = '0; e.multi_resume = 1'b1; ev;
      chk({resume_valid, resume_reg}, 5'h15);
      e = '0; e.multi_done = 1'b1; ev;
      rd(ESB_VIEW_FULL, 1'b1, 32'h01000000);
   endtask : t_multi
   task automatic t_block;
      e = '0; e.block_start = 1'b1; e.block_state = 8'h48; ev;
      chk({block_active, block_cond}, 5'h14);
      rd(ESB_VIEW_FULL, 1'b1, 32'h03002000);
      rd(ESB_VIEW_OTHER, 1'b1, 32'h00000000);
      e = '0; e.block_step = 1'b1;
      repeat (4) ev;
      chk({31'h0, block_active}, 32'h0);
   endtask : t_block
   task automatic t_istate;
      ex(1'b0);
      upd(ESB_ISRC_BRANCH, 1'b0, 32'h0);
      rd(ESB_VIEW_FULL, 1'b1, 32'h00000000);
      ex(1'b1);
      upd(ESB_ISRC_RETURN, 1'b0, 32'h01005000);
      rd(ESB_VIEW_FULL, 1'b1, 32'h01005000);
      upd(ESB_ISRC_VECTOR, 1'b0, 32'h0);
      rd(ESB_VIEW_FULL, 1'b1, 32'h00005000);
      upd(ESB_ISRC_VECTOR, 1'b1, 32'h0);
      ex(1'b0);
   endtask : t_istate
   task automatic close_out;
      if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : close_out
   // main sequence after ten reset cycles
   initial begin
      {sys_clk, rst_n, exec_attempt, isrc_bit, stacked_word} = '0;
      {evt, e, sw} = '0;
      isrc = ESB_ISRC_NONE;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset;
      t_multi;
      t_block;
      t_istate;
      close_out;
   end
   // cuts a hang short
   initial begin
      repeat (2000) @(posedge sys_clk);
      fail_count++;
      close_out;
   end
endmodule : execution_state_bits_test
